// [src/spcs_pkg.sv]
/*
 file holds: constants, field positions and carrier types of the pcs control/status bank.
 assumes: the bank is reached over an axi4-lite slave with 32-bit data.
*/
package spcs_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [3:0]  IDX_CONTROL  = 4'h0;
    localparam logic [3:0]  IDX_STATUS   = 4'h1;
    localparam logic [3:0]  IDX_VENDOR   = 4'h4;
    localparam logic [3:0]  IDX_LINKIN   = 4'h5;
    localparam int          ADDR_LSB     = 2;
    localparam int          REG_W        = 16;

    // control field positions
    localparam int          CTL_RESET    = 15;
    localparam int          CTL_LOOP     = 14;
    localparam int          CTL_SPD_LSB  = 13;
    localparam int          CTL_AN_EN    = 12;
    localparam int          CTL_PWRDN    = 11;
    localparam int          CTL_ISOLATE  = 10;
    localparam int          CTL_AN_RST   = 9;
    localparam int          CTL_DUPLEX   = 8;
    localparam int          CTL_COLTEST  = 7;
    localparam int          CTL_SPD_MSB  = 6;
    localparam int          CTL_UNIDIR   = 5;

    // status field positions
    localparam int          STS_AN_DONE  = 5;
    localparam int          STS_RFAULT   = 4;
    localparam int          STS_LINK     = 2;

    // vendor register fields
    localparam int          VND_LOOPPOS  = 0;
    localparam int          VND_IRQ_EN   = 1;
    localparam int          VND_IRQ_STS  = 2;

    // fixed read values, writable masks and reset values
    localparam logic [15:0] CTL_FIXED    = 16'h0140;
    localparam logic [15:0] CTL_WMASK    = 16'h5c20;
    localparam logic [15:0] STS_FIXED    = 16'h01c8;
    localparam logic [15:0] VND_RESET    = 16'h0002;
    localparam logic [15:0] CTL_RESET_V  = 16'h1000;

    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic        loopback;
        logic        loop_in_xcvr;
        logic        an_enable;
        logic        power_down;
        logic        isolate;
        logic        unidir_tx;
        logic        pcs_reset;
        logic        an_restart;
    } spcs_ctrl_t;

    typedef struct packed {
        logic        an_complete;
        logic        remote_fault;
        logic        link_up;
    } spcs_evt_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_RESP = 2'b01
    } spcs_rd_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } spcs_wr_t;

endpackage

// [src/spcs_regs.sv]
/*
 file holds: pcs control and status register bank with axi4-lite slave.
 assumes: one clock, synchronous active-low reset, pcs core supplies live status levels.
*/
`timescale 1ns/100ps

module spcs_regs (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [31:0]             s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [31:0]             s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire spcs_pkg::spcs_evt_t     pcs_status,
    output spcs_pkg::spcs_ctrl_t         pcs_ctrl,
    output logic                         an_irq
);

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [3:0] reg_index(input logic [31:0] addr);
        reg_index = addr[spcs_pkg::ADDR_LSB +: 4];
    endfunction

    function automatic logic idx_valid(input logic [31:0] addr);
        logic [3:0] i;
        i = reg_index(addr);
        idx_valid = (addr[31:spcs_pkg::ADDR_LSB + 4] == '0) &&
                    ((i == spcs_pkg::IDX_CONTROL) || (i == spcs_pkg::IDX_STATUS) ||
                     (i == spcs_pkg::IDX_VENDOR)  || (i == spcs_pkg::IDX_LINKIN));
    endfunction

    function automatic logic idx_is(input logic [31:0] addr, input logic [3:0] idx);
        idx_is = (reg_index(addr) == idx);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks; views and masks assume one register width

    if (spcs_pkg::REG_W != $bits(spcs_pkg::CTL_FIXED)) begin : g_bad_width
        $error("register width not served by this bank");
    end
    if ((spcs_pkg::CTL_WMASK & spcs_pkg::CTL_FIXED) != '0) begin : g_bad_mask
        $error("writable and fixed control bits overlap");
    end

    ////////////////////////////////////////////////////////////////////////
    // state

    spcs_pkg::spcs_wr_t  wr_st_reg,     wr_st_next;
    spcs_pkg::spcs_rd_t  rd_st_reg,     rd_st_next;
    logic                aw_hold_reg,   aw_hold_next;
    logic                w_hold_reg,    w_hold_next;
    logic [31:0]         awaddr_reg,    awaddr_next;
    logic [31:0]         wdata_reg,     wdata_next;
    logic [3:0]          wstrb_reg,     wstrb_next;
    logic [1:0]          bresp_reg,     bresp_next;
    logic [31:0]         rdata_reg,     rdata_next;
    logic [1:0]          rresp_reg,     rresp_next;
    logic [3:0]          rd_idx_reg,    rd_idx_next;
    logic                clr_on_rd_reg, clr_on_rd_next;
    logic [15:0]         ctl_reg,       ctl_next;
    logic                rst_pulse_reg, rst_pulse_next;
    logic                an_rst_reg,    an_rst_next;
    logic                rfault_reg,    rfault_next;
    logic                link_reg,      link_next;
    logic                done_q_reg,    done_q_next;
    logic                loop_pos_reg,  loop_pos_next;
    logic                irq_en_reg,    irq_en_next;
    logic                irq_sts_reg,   irq_sts_next;

    logic                do_write;
    logic [15:0]         wr16;
    logic [15:0]         sts_view;
    logic [15:0]         ctl_view;
    logic [15:0]         vnd_view;

    ////////////////////////////////////////////////////////////////////////
    // read views

    always_comb begin
        ctl_view = (ctl_reg & spcs_pkg::CTL_WMASK)
                   | spcs_pkg::CTL_FIXED;
        sts_view = spcs_pkg::STS_FIXED;
        sts_view[spcs_pkg::STS_AN_DONE] = pcs_status.an_complete;
        sts_view[spcs_pkg::STS_RFAULT]  = rfault_reg;
        sts_view[spcs_pkg::STS_LINK]    = link_reg;
        vnd_view = '0;
        vnd_view[spcs_pkg::VND_LOOPPOS] = loop_pos_reg;
        vnd_view[spcs_pkg::VND_IRQ_EN]  = irq_en_reg;
        vnd_view[spcs_pkg::VND_IRQ_STS] = irq_sts_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // write channel

    always_comb begin
        wr_st_next   = wr_st_reg;
        aw_hold_next = aw_hold_reg;
        w_hold_next  = w_hold_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bresp_next   = bresp_reg;
        do_write     = 1'b0;
        case (wr_st_reg)
            spcs_pkg::WR_IDLE: begin
                if (s_axi_awvalid && !aw_hold_reg) begin
                    aw_hold_next = 1'b1;
                    awaddr_next  = s_axi_awaddr;
                end
                if (s_axi_wvalid && !w_hold_reg) begin
                    w_hold_next = 1'b1;
                    wdata_next  = s_axi_wdata;
                    wstrb_next  = s_axi_wstrb;
                end
                if (aw_hold_reg && w_hold_reg) begin
                    do_write     = idx_valid(awaddr_reg);
                    bresp_next   = idx_valid(awaddr_reg) ? spcs_pkg::RESP_OKAY
                                                         : spcs_pkg::RESP_SLVERR;
                    aw_hold_next = 1'b0;
                    w_hold_next  = 1'b0;
                    wr_st_next   = spcs_pkg::WR_RESP;
                end
            end
            spcs_pkg::WR_RESP: begin
                if (s_axi_bready) begin
                    wr_st_next = spcs_pkg::WR_IDLE;
                end
            end
            default: begin
                wr_st_next = spcs_pkg::WR_IDLE;
            end
        endcase
    end

    // ready drops while an item is held, so each channel gives one item per write
    assign s_axi_awready = (wr_st_reg == spcs_pkg::WR_IDLE) && !aw_hold_reg;
    assign s_axi_wready  = (wr_st_reg == spcs_pkg::WR_IDLE) && !w_hold_reg;
    assign s_axi_bvalid  = (wr_st_reg == spcs_pkg::WR_RESP);
    assign s_axi_bresp   = bresp_reg;
    // lanes 0 and 1 only; upper lanes land on bits that read zero
    assign wr16 = {wstrb_reg[1] ? wdata_reg[15:8] : 8'h00,
                   wstrb_reg[0] ? wdata_reg[7:0]  : 8'h00};

    ////////////////////////////////////////////////////////////////////////
    // read channel

    always_comb begin
        rd_st_next     = rd_st_reg;
        rdata_next     = rdata_reg;
        rresp_next     = rresp_reg;
        clr_on_rd_next = 1'b0;
        case (rd_st_reg)
            spcs_pkg::RD_IDLE: begin
                if (s_axi_arvalid) begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = spcs_pkg::RESP_OKAY;
                    if (!idx_valid(s_axi_araddr)) begin
                        rresp_next = spcs_pkg::RESP_SLVERR;
                    end else if (reg_index(s_axi_araddr) == spcs_pkg::IDX_CONTROL) begin
                        rdata_next[15:0] = ctl_view;
                    end else if (reg_index(s_axi_araddr) == spcs_pkg::IDX_STATUS) begin
                        rdata_next[15:0] = sts_view;
                    end else if (reg_index(s_axi_araddr) == spcs_pkg::IDX_VENDOR) begin
                        rdata_next[15:0] = vnd_view;
                    end else begin
                        rdata_next[spcs_pkg::STS_LINK] = pcs_status.link_up;
                    end
                    rd_st_next = spcs_pkg::RD_RESP;
                end
            end
            spcs_pkg::RD_RESP: begin
                if (s_axi_rready) begin
                    // clear only after the master has taken the data
                    clr_on_rd_next = (rdata_reg[31:16] == '0) && (rresp_reg == spcs_pkg::RESP_OKAY)
                                     && (rd_idx_reg == spcs_pkg::IDX_STATUS);
                    rd_st_next = spcs_pkg::RD_IDLE;
                end
            end
            default: begin
                rd_st_next = spcs_pkg::RD_IDLE;
            end
        endcase
    end

    // index kept apart from rdata; the clear also needs returned rdata bits 31:16 to be zero
    assign rd_idx_next = (rd_st_reg == spcs_pkg::RD_IDLE && s_axi_arvalid)
                         ? reg_index(s_axi_araddr) : rd_idx_reg;

    // rdata stands until rready; no new read is taken meanwhile
    assign s_axi_arready = (rd_st_reg == spcs_pkg::RD_IDLE);
    assign s_axi_rvalid  = (rd_st_reg == spcs_pkg::RD_RESP);
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // register bank

    always_comb begin
        ctl_next       = ctl_reg;
        rst_pulse_next = 1'b0;
        an_rst_next    = 1'b0;
        loop_pos_next  = loop_pos_reg;
        irq_en_next    = irq_en_reg;
        irq_sts_next   = irq_sts_reg;
        done_q_next    = pcs_status.an_complete;
        rfault_next    = rfault_reg;
        link_next      = link_reg;
        if (do_write && idx_is(awaddr_reg, spcs_pkg::IDX_CONTROL)) begin
            ctl_next[spcs_pkg::CTL_LOOP]    = wr16[spcs_pkg::CTL_LOOP];
            ctl_next[spcs_pkg::CTL_AN_EN]   = wr16[spcs_pkg::CTL_AN_EN];
            ctl_next[spcs_pkg::CTL_ISOLATE] = wr16[spcs_pkg::CTL_ISOLATE];
            ctl_next[spcs_pkg::CTL_UNIDIR]  = wr16[spcs_pkg::CTL_UNIDIR];
            // power down is sticky; writing 0 does not wake the transceiver
            ctl_next[spcs_pkg::CTL_PWRDN]   = ctl_reg[spcs_pkg::CTL_PWRDN]
                                              | wr16[spcs_pkg::CTL_PWRDN];
            rst_pulse_next = wr16[spcs_pkg::CTL_RESET];
            an_rst_next    = wr16[spcs_pkg::CTL_AN_RST];
        end
        if (do_write && idx_is(awaddr_reg, spcs_pkg::IDX_VENDOR)) begin
            loop_pos_next = wr16[spcs_pkg::VND_LOOPPOS];
            irq_en_next   = wr16[spcs_pkg::VND_IRQ_EN];
            if (!wr16[spcs_pkg::VND_IRQ_STS]) begin
                irq_sts_next = 1'b0;
            end
        end
        // defaults land the cycle after the reset pulse reaches the core, two cycles after the write
        if (rst_pulse_reg) begin
            ctl_next = spcs_pkg::CTL_RESET_V;
        end
        // a disabled flag is held low
        if (!irq_en_next) begin
            irq_sts_next = 1'b0;
        end else if (pcs_status.an_complete && !done_q_reg) begin
            irq_sts_next = 1'b1;
        end
        if (clr_on_rd_reg) begin
            rfault_next = 1'b0;
            link_next   = 1'b0;
        end
        // set wins over the read clear
        if (pcs_status.remote_fault) begin
            rfault_next = 1'b1;
        end
        if (pcs_status.link_up && !link_reg && !clr_on_rd_reg) begin
            link_next = 1'b1;
        end else if (pcs_status.link_up && clr_on_rd_reg) begin
            link_next = 1'b1;
        end
    end

    // write state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_st_reg     <= spcs_pkg::WR_IDLE;
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            awaddr_reg    <= 32'h0000_0000;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
            bresp_reg     <= spcs_pkg::RESP_OKAY;
        end else begin
            wr_st_reg     <= wr_st_next;
            aw_hold_reg   <= aw_hold_next;
            w_hold_reg    <= w_hold_next;
            awaddr_reg    <= awaddr_next;
            wdata_reg     <= wdata_next;
            wstrb_reg     <= wstrb_next;
            bresp_reg     <= bresp_next;
        end
    end

    // read state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_st_reg     <= spcs_pkg::RD_IDLE;
            rdata_reg     <= 32'h0000_0000;
            rresp_reg     <= spcs_pkg::RESP_OKAY;
            rd_idx_reg    <= 4'h0;
            clr_on_rd_reg <= 1'b0;
        end else begin
            rd_st_reg     <= rd_st_next;
            rdata_reg     <= rdata_next;
            rresp_reg     <= rresp_next;
            rd_idx_reg    <= rd_idx_next;
            clr_on_rd_reg <= clr_on_rd_next;
        end
    end

    // bank state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_reg       <= spcs_pkg::CTL_RESET_V;
            rst_pulse_reg <= 1'b0;
            an_rst_reg    <= 1'b0;
            rfault_reg    <= 1'b0;
            link_reg      <= 1'b0;
            done_q_reg    <= 1'b0;
            loop_pos_reg  <= 1'b0;
            irq_en_reg    <= spcs_pkg::VND_RESET[spcs_pkg::VND_IRQ_EN];
            irq_sts_reg   <= 1'b0;
        end else begin
            ctl_reg       <= ctl_next;
            rst_pulse_reg <= rst_pulse_next;
            an_rst_reg    <= an_rst_next;
            rfault_reg    <= rfault_next;
            link_reg      <= link_next;
            done_q_reg    <= done_q_next;
            loop_pos_reg  <= loop_pos_next;
            irq_en_reg    <= irq_en_next;
            irq_sts_reg   <= irq_sts_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs to the pcs core

    always_comb begin
        pcs_ctrl.loopback     = ctl_reg[spcs_pkg::CTL_LOOP];
        pcs_ctrl.loop_in_xcvr = loop_pos_reg;
        pcs_ctrl.an_enable    = ctl_reg[spcs_pkg::CTL_AN_EN];
        pcs_ctrl.power_down   = ctl_reg[spcs_pkg::CTL_PWRDN];
        pcs_ctrl.isolate      = ctl_reg[spcs_pkg::CTL_ISOLATE];
        pcs_ctrl.unidir_tx    = ctl_reg[spcs_pkg::CTL_UNIDIR];
        pcs_ctrl.pcs_reset    = rst_pulse_reg;
        pcs_ctrl.an_restart   = an_rst_reg;
    end

    // level flag; software clears it or disables it
    assign an_irq = irq_sts_reg;

endmodule

// [dv/spcs_regs_checker.sv]
/* assertions and covers on the ports of the pcs control/status bank.
   assumes: bound into spcs_regs, one clock, synchronous active-low reset. */
`timescale 1ns/100ps
module spcs_regs_checker (
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_wvalid,
    input wire logic                 s_axi_wready,
    input wire logic                 s_axi_bvalid,
    input wire logic [31:0]          s_axi_araddr,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    input wire spcs_pkg::spcs_evt_t  pcs_status,
    input wire spcs_pkg::spcs_ctrl_t pcs_ctrl,
    input wire logic                 an_irq
);
    logic [31:0] ra_reg;
    logic [31:0] ra_next;
    // read address kept so returned data can be judged per register
    always_comb begin
        ra_next = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ra_reg;
    end
    always_ff @(posedge aclk) begin
        ra_reg <= ra_next;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    rst_pulse_a: assert property (pcs_ctrl.pcs_reset |=> !pcs_ctrl.pcs_reset)
        else $error("pcs reset pulse longer than one cycle");
    pd_clear_a: assert property ($fell(pcs_ctrl.power_down) |-> pcs_ctrl.pcs_reset
        || $past(pcs_ctrl.pcs_reset) || $past(pcs_ctrl.pcs_reset, 2))
        else $error("power down cleared without pcs reset");
    an_pulse_a: assert property (pcs_ctrl.an_restart |=> !pcs_ctrl.an_restart)
        else $error("restart pulse longer than one cycle");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before accepted");
    sts_fixed_a: assert property (
        s_axi_rvalid && ra_reg == 32'h00000004 |-> (s_axi_rdata & 32'hffffffcb) == 32'h000001c8)
        else $error("status fixed bits wrong");
    ctl_fixed_a: assert property (
        s_axi_rvalid && ra_reg == 32'h00000000 |-> (s_axi_rdata & 32'hffffa3df) == 32'h00000140)
        else $error("control fixed bits wrong");
    irq_set_a: assert property ($rose(an_irq) |-> $past(pcs_status.an_complete)
        || $past(pcs_status.an_complete, 2))
        else $error("flag set without completion");
    cover property (s_axi_rvalid && s_axi_rready && ra_reg == 32'h00000004);
    cover property (pcs_ctrl.pcs_reset);
    cover property ($rose(an_irq));
endmodule

// [dv/spcs_phy_model.sv]
/* behavioural far side: pcs core and phy status levels seen by the bank.
   assumes: bench steers fault and link; completion follows a restart while an_enable is set. */
`timescale 1ns/100ps
module spcs_phy_model #(
    parameter int AN_DLY = 20
) (
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire spcs_pkg::spcs_ctrl_t pcs_ctrl,
    input wire logic                 fault_req,
    input wire logic                 link_req,
    output spcs_pkg::spcs_evt_t      pcs_status
);
    logic [7:0]          cnt_reg;
    logic [7:0]          cnt_next;
    spcs_pkg::spcs_evt_t st_next;
    always_comb begin
        cnt_next = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
        st_next = pcs_status;
        st_next.remote_fault = fault_req;
        st_next.link_up = link_req;
        // completion drops for the length of a fresh negotiation
        if (pcs_ctrl.an_restart && pcs_ctrl.an_enable) begin
            cnt_next = AN_DLY[7:0];
            st_next.an_complete = 1'b0;
        end else if (cnt_reg == 8'h01) begin
            st_next.an_complete = 1'b1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 8'h00;
            pcs_status <= '0;
        end else begin
            cnt_reg <= cnt_next;
            pcs_status <= st_next;
        end
    end
endmodule

// [dv/spcs_regs_tb.sv]
/* self-checking bench for the pcs control/status bank over axi4-lite.
   assumes: spcs_pkg compiled first; phy model supplies live status. */
`timescale 1ns/100ps
module spcs_regs_tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fault_req, link_req;
    logic awready, wready, bvalid, arready, rvalid, an_irq, pd;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic [15:0] d;
    spcs_pkg::spcs_evt_t  pcs_status;
    spcs_pkg::spcs_ctrl_t pcs_ctrl;
    int err_total, tests_run, seed, k, an_cnt, pr_cnt;
    spcs_regs spcs_regs_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pcs_status(pcs_status), .pcs_ctrl(pcs_ctrl), .an_irq(an_irq));
    spcs_phy_model spcs_phy_model_inst (.aclk(aclk), .aresetn(aresetn), .pcs_ctrl(pcs_ctrl),
        .fault_req(fault_req), .link_req(link_req), .pcs_status(pcs_status));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        an_cnt = an_cnt + pcs_ctrl.an_restart;
        pr_cnt = pr_cnt + pcs_ctrl.pcs_reset;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ready is sampled mid-cycle; inputs only move at rising edges
    task automatic axw(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
        logic aw_ok, w_ok, b_ok;
        b_ok = 1'b0;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
        while (!b_ok) begin
            @(negedge aclk);
            {aw_ok, w_ok, b_ok, r} = {awvalid & awready, wvalid & wready, bvalid, bresp};
            @(posedge aclk);
            {awvalid, wvalid, bready} <= {awvalid & ~aw_ok, wvalid & ~w_ok, ~b_ok};
        end
    endtask
    task automatic axr(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
        logic a_ok, r_ok;
        r_ok = 1'b0;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        while (!r_ok) begin
            @(negedge aclk);
            {a_ok, r_ok, v, r} = {arvalid & arready, rvalid, rdata, rresp};
            @(posedge aclk);
            {arvalid, rready} <= {arvalid & ~a_ok, ~r_ok};
        end
    endtask
    function automatic logic [31:0] ctl_exp(input logic [15:0] w, input logic p);
        return {16'h0, (w & spcs_pkg::CTL_WMASK & 16'hf7ff) | {4'h0, p, 11'h0}
            | spcs_pkg::CTL_FIXED};
    endfunction
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
        {fault_req, link_req, aresetn, pd, err_total, tests_run, an_cnt, pr_cnt} = '0;
        wstrb = 4'hf;
        seed = 58602;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axr(32'h0, rd, rs);
        chk(rd, 32'h1140);
        axr(32'h4, rd, rs);
        chk(rd, {16'h0, spcs_pkg::STS_FIXED});
        chk({24'h0, pcs_ctrl}, 32'h20);
        done("reset");
        // bits 15 and 9 kept out: their pulses are tested on their own
        for (k = 0; k < 12; k++) begin
            d = (k == 0) ? 16'h249f : 16'($random(seed)) & 16'h7dff;
            pd = pd | d[11];
            axw(32'h0, {16'h0, d}, rs);
            axr(32'h0, rd, rs);
            chk(rd, ctl_exp(d, pd));
            chk({24'h0, pcs_ctrl},
                {24'h0, d[14], 1'b0, d[12], pd, d[10], d[5], 2'b0});
        end
        done("control");
        axw(32'h0, 32'h1200, rs);
        axr(32'h0, rd, rs);
        chk(an_cnt, 1);
        chk(rd, ctl_exp(16'h1000, pd));
        k = 0;
        do axr(32'h4, rd, rs); while (!rd[5] && k++ < 50);
        chk({31'h0, rd[5]}, 32'h1);
        chk({31'h0, an_irq}, 32'h1);
        axw(32'h10, 32'h3, rs);
        axr(32'h10, rd, rs);
        chk(rd, 32'h3);
        chk({30'h0, pcs_ctrl.loop_in_xcvr, an_irq}, 32'h2);
        axw(32'h10, 32'h2, rs);
        done("negotiation");
        axw(32'h0, 32'h8000, rs);
        axr(32'h0, rd, rs);
        pd = 1'b0;
        chk(pr_cnt, 1);
        chk(rd, 32'h1140);
        chk({24'h0, pcs_ctrl}, 32'h20);
        done("pcs reset");
        {fault_req, link_req} <= 2'b11;
        @(posedge aclk);
        fault_req <= 1'b0;
        repeat (3) @(posedge aclk);
        axr(32'h4, rd, rs);
        chk(rd, 32'h1fc);
        axr(32'h4, rd, rs);
        chk(rd, 32'h1ec);
        link_req <= 1'b0;
        repeat (3) @(posedge aclk);
        axr(32'h4, rd, rs);
        chk(rd, 32'h1ec);
        axr(32'h4, rd, rs);
        chk(rd, 32'h1e8);
        done("latches");
        axr(32'h8, rd, rs);
        chk(rd, 32'h0);
        chk({30'h0, rs}, {30'h0, spcs_pkg::RESP_SLVERR});
        axw(32'hc, 32'hffff, rs);
        chk({30'h0, rs}, {30'h0, spcs_pkg::RESP_SLVERR});
        axw(32'h4, 32'h0, rs);
        axr(32'h4, rd, rs);
        chk(rd, 32'h1e8);
        wstrb <= 4'h1;
        axw(32'h0, 32'h5c20, rs);
        wstrb <= 4'hf;
        axr(32'h0, rd, rs);
        chk(rd, ctl_exp(16'h0020, pd));
        done("unmapped");
        end_sim();
    end
endmodule
bind spcs_regs spcs_regs_checker spcs_regs_checker_inst (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pcs_status, .pcs_ctrl, .an_irq);
